// file: logic/sfp_defs.svh
// Constants for the serial register and buffer port.
`ifndef SFP_DEFS_SVH
`define SFP_DEFS_SVH

// ----------------------------------------------------------------------
// Address map of the configuration space
// ----------------------------------------------------------------------
`define SFP_FIFO_ADDR      7'h00
`define SFP_MODE_ADDR      7'h01
`define SFP_STATUS_ADDR    7'h02

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define SFP_ST_HAS_DATA    0
`define SFP_ST_FULL        1
`define SFP_ST_OVERRUN     2
`define SFP_ST_SETTLED     3
`define SFP_MODE_CONT_BIT  3
`define SFP_MODE_RESET     3'h1
`define SFP_FIFO_DEPTH     66

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SFP_MCLK_PERIOD_NS 10
`define SFP_BIT_TIME_NS    1000
`define SFP_BIT_CYCLES \
  ((`SFP_BIT_TIME_NS + `SFP_MCLK_PERIOD_NS - 1) / `SFP_MCLK_PERIOD_NS)

`endif

// file: logic/sfp_pkg.sv
// Types shared by the serial register and buffer port.
package sfp_pkg;

  // ----------------------------------------------------------------------
  // Operating modes and settle states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SFP_SLEEP = 3'b000,
    SFP_STDBY = 3'b001,
    SFP_FS    = 3'b010,
    SFP_TX    = 3'b011,
    SFP_RX    = 3'b100
  } sfp_mode_t;

  typedef enum logic [0:0] {
    SFP_ST_READY = 1'b0,
    SFP_ST_DRAIN = 1'b1
  } sfp_settle_t;

  // ----------------------------------------------------------------------
  // One received serial byte handed to the system clock side
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       is_addr;
    logic [7:0] data;
  } sfp_byte_evt_t;

endpackage : sfp_pkg

// file: logic/sfp_port.sv
// Serial slave port with configuration space, byte buffer and bit shifter.
// Summary of operation
// - Slave only, clock idle low, sample first edge.
// - Master drives MOSI falling, device samples rising.
// - MISO changes on each falling clock edge.
// - MISO released while select high.
// - First byte is address, top bit write flag.
// - Seven address bits follow, MSB first.
// - Data bytes shift MSB first both directions.
// - Non-buffer address increments after each byte.
// - Buffer address stays fixed, bytes push or pop.
// - Select high ends frame; next byte is address.
// - Single access is a one-byte burst.
// - Write returns previous register content on MISO.
// - Buffer is 66 entries of one byte.
// - Transmit shifter pops bytes, sends MSB first.
// - Receive shifter packs bits, pushes bytes.
// - Continuous mode bypasses buffer on data pin.
// - Has-data low when empty, refreshed at select rise.
// - Push into full sets overrun; clearing empties buffer.
// - Buffer flushed on listed mode transitions.
`timescale 1ns/1ps
`include "sfp_defs.svh"

module sfp_port
  import sfp_pkg::*;
(
  input  wire logic MCLK,
  input  wire logic RST_N,
  input  wire logic SCK,
  input  wire logic SLAVE_SELECT_N,
  input  wire logic MOSI,
  output logic      MISO,
  output logic      MISO_OE,
  input  wire logic DEMOD_BIT,
  output logic      MOD_TX_BIT,
  input  wire logic SERIAL_DATA_PIN_I,
  output logic      SERIAL_DATA_PIN_O,
  output logic      SERIAL_DATA_PIN_OE,
  output logic      BUFFER_HAS_DATA,
  output logic      BUFFER_OVERRUN_FLAG,
  output logic      MODE_SETTLED_FLAG
);

  // ----------------------------------------------------------------------
  // Serial clock domain
  // ----------------------------------------------------------------------
  logic          sck_arst_n;
  logic [2:0]    bit_cnt_q;
  logic [6:0]    rx_q;
  logic          have_addr_q;
  logic [7:0]    tx_q;
  logic          tx_next_bit;
  sfp_byte_evt_t evt_q;
  logic          tgl_q;
  logic [7:0]    rx_byte;
  logic          byte_done;
  logic [7:0]    rdata_q;

  // Select high holds the frame logic in reset, so each frame starts fresh.
  assign sck_arst_n  = RST_N & ~SLAVE_SELECT_N;
  assign rx_byte     = {rx_q, MOSI};
  assign byte_done   = (bit_cnt_q == 3'h7);
  assign tx_next_bit = tx_q[6];

  // MOSI is sampled on the rising edge, MSB first.
  always_ff @(posedge SCK or negedge sck_arst_n) begin
    if (!sck_arst_n) begin
      bit_cnt_q   <= 3'h0;
      rx_q        <= 7'h00;
      have_addr_q <= 1'b0;
      MISO_OE     <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      rx_q      <= rx_byte[6:0];
      MISO_OE   <= 1'b1;
      if (byte_done) begin
        have_addr_q <= 1'b1;
      end
    end
  end

  // The byte word and its toggle survive select, or a frame end would
  // fake an event on the other side.
  always_ff @(posedge SCK or negedge RST_N) begin
    if (!RST_N) begin
      evt_q <= '0;
      tgl_q <= 1'b0;
    end else if (byte_done && sck_arst_n) begin
      evt_q <= '{is_addr: ~have_addr_q, data: rx_byte};
      tgl_q <= ~tgl_q;
    end
  end

  // MISO moves on the falling edge. The read word is taken only after the
  // other side has answered the byte event, so it is stable by then; this
  // needs the serial clock no faster than the bench rate.
  always_ff @(negedge SCK or negedge sck_arst_n) begin
    if (!sck_arst_n) begin
      tx_q <= 8'h00;
    end else if (bit_cnt_q == 3'h0) begin
      tx_q <= have_addr_q ? rdata_q : 8'h00;
    end else begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  assign MISO = tx_q[7];

  a_miso_shift: assert property (
    @(posedge SCK) disable iff (!sck_arst_n)
    (have_addr_q && bit_cnt_q != 3'h0) |-> MISO == $past(tx_next_bit))
    else $error("MISO did not advance on the falling edge.");

  a_miso_float: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    SLAVE_SELECT_N |-> !MISO_OE)
    else $error("MISO driven while select is high.");

  // ----------------------------------------------------------------------
  // Crossings into the system clock domain
  // ----------------------------------------------------------------------
  logic ss_s;
  logic tgl_s;
  logic sdi_s;
  logic tgl_seen_q;

  sfp_sync3 #(.INIT(1'b1)) u_ss_sync (
    .clk   (MCLK),
    .rst_n (RST_N),
    .d     (SLAVE_SELECT_N),
    .q     (ss_s)
  );

  sfp_sync3 #(.INIT(1'b0)) u_tgl_sync (
    .clk   (MCLK),
    .rst_n (RST_N),
    .d     (tgl_q),
    .q     (tgl_s)
  );

  sfp_sync3 #(.INIT(1'b0)) u_sdi_sync (
    .clk   (MCLK),
    .rst_n (RST_N),
    .d     (SERIAL_DATA_PIN_I),
    .q     (sdi_s)
  );

  // ----------------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------------
  logic       byte_evt;
  logic       is_addr_evt;
  logic       data_evt;
  logic [6:0] addr_q;
  logic [6:0] addr_d;
  logic       wnr_q;
  logic       frame_q;
  logic       at_fifo;
  logic       host_wr;
  logic       host_push;
  logic       host_pop;
  logic       cfg_wr;
  logic       mode_wr;
  logic       ovr_clr;

  assign byte_evt    = tgl_s ^ tgl_seen_q;
  assign is_addr_evt = byte_evt & evt_q.is_addr;
  assign data_evt    = byte_evt & ~evt_q.is_addr;
  assign at_fifo     = (addr_q == `SFP_FIFO_ADDR);
  assign host_wr     = data_evt & wnr_q;
  assign host_push   = host_wr & at_fifo;
  assign cfg_wr      = host_wr & ~at_fifo;
  assign mode_wr     = cfg_wr & (addr_q == `SFP_MODE_ADDR);
  assign ovr_clr     = cfg_wr & (addr_q == `SFP_STATUS_ADDR)
                       & evt_q.data[`SFP_ST_OVERRUN];

  // Buffer address holds; any other address steps after each data byte.
  assign addr_d = is_addr_evt ? evt_q.data[6:0] :
                  (data_evt && !at_fifo) ? addr_q + 7'h01 :
                  addr_q;

  // Address byte latches direction and start address.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      addr_q     <= 7'h00;
      wnr_q      <= 1'b0;
      frame_q    <= 1'b0;
      tgl_seen_q <= 1'b0;
    end else begin
      tgl_seen_q <= tgl_s;
      addr_q     <= addr_d;
      if (is_addr_evt) begin
        wnr_q   <= evt_q.data[7];
        frame_q <= 1'b1;
      end else if (ss_s) begin
        frame_q <= 1'b0;
      end
    end
  end

  a_addr_hold: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    (data_evt && at_fifo) |=> (addr_q == `SFP_FIFO_ADDR))
    else $error("Buffer address moved inside a frame.");

  a_burst_step: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    (data_evt && !at_fifo) |=> (addr_q == $past(addr_q) + 7'h01))
    else $error("Burst address did not step by one.");

  // ----------------------------------------------------------------------
  // Byte buffer
  // ----------------------------------------------------------------------
  logic [7:0] fifo_mem [0:`SFP_FIFO_DEPTH-1];
  logic [6:0] wr_ptr_q;
  logic [6:0] rd_ptr_q;
  logic [6:0] rd_ptr_d;
  logic [6:0] count_q;
  logic [6:0] wr_ptr_inc;
  logic [6:0] rd_ptr_inc;
  logic       full;
  logic       empty;
  logic       push_req;
  logic       push;
  logic       pop;
  logic       flush;
  logic       mode_flush;
  logic       sr_push;
  logic       sr_pop;
  logic [7:0] sr_byte;
  logic [7:0] push_data;
  logic       rx_pkt;
  logic       tx_pkt;
  logic       overrun_q;
  logic [7:0] fifo_head;

  localparam logic [6:0] LAST_IDX = 7'(`SFP_FIFO_DEPTH - 1);

  assign full       = (count_q == 7'(`SFP_FIFO_DEPTH));
  assign empty      = (count_q == 7'h00);
  assign host_pop   = data_evt & ~wnr_q & at_fifo & ~empty;
  assign push_req   = rx_pkt ? sr_push : host_push;
  assign push_data  = rx_pkt ? sr_byte : evt_q.data;
  assign push       = push_req & ~full;
  assign pop        = tx_pkt ? sr_pop : host_pop;
  assign flush      = mode_flush | ovr_clr;
  assign wr_ptr_inc = (wr_ptr_q == LAST_IDX) ? 7'h00 : wr_ptr_q + 7'h01;
  assign rd_ptr_inc = (rd_ptr_q == LAST_IDX) ? 7'h00 : rd_ptr_q + 7'h01;
  assign rd_ptr_d   = flush ? 7'h00 : pop ? rd_ptr_inc : rd_ptr_q;
  assign fifo_head  = fifo_mem[rd_ptr_q];

  // Pointers and fill level; a flush wins over a same-cycle push or pop.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_ptr_q <= 7'h00;
      rd_ptr_q <= 7'h00;
      count_q  <= 7'h00;
    end else if (flush) begin
      wr_ptr_q <= 7'h00;
      rd_ptr_q <= 7'h00;
      count_q  <= 7'h00;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_inc;
      end
      rd_ptr_q <= rd_ptr_d;
      count_q  <= count_q + {6'h00, push} - {6'h00, pop};
    end
  end

  // Storage needs no reset; the fill level says what is valid.
  always_ff @(posedge MCLK) begin
    if (push && !flush) begin
      fifo_mem[wr_ptr_q] <= push_data;
    end
  end

  // A byte lost to a full buffer sets the flag even as it is cleared.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      overrun_q <= 1'b0;
    end else begin
      overrun_q <= (push_req & full) | (overrun_q & ~ovr_clr);
    end
  end

  assign BUFFER_OVERRUN_FLAG = overrun_q;

  a_level_cap: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    count_q <= 7'(`SFP_FIFO_DEPTH))
    else $error("Buffer level above its depth.");

  a_overrun_set: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    (push_req && full) |=> overrun_q && $stable(wr_ptr_q))
    else $error("Push into full buffer not flagged or not dropped.");

  a_flush_empty: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    flush |=> (count_q == 7'h00) ##1 (count_q <= 7'h01))
    else $error("Buffer not emptied by flush.");

  // ----------------------------------------------------------------------
  // Modes and settling
  // ----------------------------------------------------------------------
  sfp_mode_t   mode_q;
  sfp_mode_t   new_mode;
  logic        cont_q;
  sfp_settle_t settle_q;
  logic        settled_q;
  logic        leave_tx;
  logic        sh_busy;
  logic        from_idle;
  logic [3:0]  sh_bits_q;

  assign new_mode   = sfp_mode_t'(evt_q.data[2:0]);
  assign leave_tx   = mode_wr & (mode_q == SFP_TX) & (new_mode != SFP_TX);
  assign from_idle  = (mode_q == SFP_SLEEP) | (mode_q == SFP_STDBY);
  assign sh_busy    = (sh_bits_q != 4'h0);
  // Flush on entry to receive from idle, receive to transmit, leaving tx.
  assign mode_flush = (mode_wr & (((new_mode == SFP_RX) & from_idle) |
                      ((mode_q == SFP_RX) & (new_mode == SFP_TX)))) |
                      (leave_tx & ~sh_busy) |
                      ((settle_q == SFP_ST_DRAIN) & ~sh_busy);
  assign rx_pkt     = (mode_q == SFP_RX) & ~cont_q;
  assign tx_pkt     = ((mode_q == SFP_TX) & ~cont_q) |
                      (settle_q == SFP_ST_DRAIN);

  // Leaving transmit waits for the byte on air; other changes settle at once.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_q    <= sfp_mode_t'(`SFP_MODE_RESET);
      cont_q    <= 1'b0;
      settle_q  <= SFP_ST_READY;
      settled_q <= 1'b1;
    end else begin
      if (mode_wr) begin
        mode_q <= new_mode;
        cont_q <= evt_q.data[`SFP_MODE_CONT_BIT];
      end
      case (settle_q)
        SFP_ST_READY: begin
          settled_q <= ~mode_wr;
          if (leave_tx && sh_busy) begin
            settle_q <= SFP_ST_DRAIN;
          end
        end
        SFP_ST_DRAIN: begin
          settled_q <= ~sh_busy;
          if (!sh_busy) begin
            settle_q <= SFP_ST_READY;
          end
        end
        default: begin
          settle_q <= SFP_ST_READY;
        end
      endcase
    end
  end

  assign MODE_SETTLED_FLAG = settled_q;

  // ----------------------------------------------------------------------
  // Bit shifter between buffer and modem
  // ----------------------------------------------------------------------
  logic [15:0] tick_cnt_q;
  logic        tick;
  logic [7:0]  sh_q;

  assign tick    = (tick_cnt_q == 16'(`SFP_BIT_CYCLES - 1));
  assign sr_pop  = tick & ~sh_busy & ~empty & (mode_q == SFP_TX) & ~cont_q;
  assign sr_push = tick & rx_pkt & (sh_bits_q == 4'h7);
  assign sr_byte = {sh_q[6:0], DEMOD_BIT};

  // Bit-rate timer.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_cnt_q <= 16'h0000;
    end else begin
      tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
    end
  end

  // Transmit sends MSB first; receive packs bits; continuous bypasses both.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sh_q       <= 8'h00;
      sh_bits_q  <= 4'h0;
      MOD_TX_BIT <= 1'b0;
    end else if (cont_q && mode_q == SFP_TX && settle_q == SFP_ST_READY) begin
      sh_bits_q  <= 4'h0;
      MOD_TX_BIT <= sdi_s;
    end else if (tx_pkt) begin
      if (sr_pop) begin
        MOD_TX_BIT <= fifo_head[7];
        sh_q       <= {fifo_head[6:0], 1'b0};
        sh_bits_q  <= 4'h7;
      end else if (tick && sh_busy) begin
        MOD_TX_BIT <= sh_q[7];
        sh_q       <= {sh_q[6:0], 1'b0};
        sh_bits_q  <= sh_bits_q - 4'h1;
      end
    end else if (rx_pkt) begin
      if (tick) begin
        sh_q      <= sr_byte;
        sh_bits_q <= (sh_bits_q == 4'h7) ? 4'h0 : sh_bits_q + 4'h1;
      end
    end else begin
      sh_bits_q  <= 4'h0;
      MOD_TX_BIT <= 1'b0;
    end
  end

  // Received bits go straight out on the data pin in continuous receive.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      SERIAL_DATA_PIN_O  <= 1'b0;
      SERIAL_DATA_PIN_OE <= 1'b0;
    end else begin
      SERIAL_DATA_PIN_O  <= cont_q & (mode_q == SFP_RX) & DEMOD_BIT;
      SERIAL_DATA_PIN_OE <= cont_q & (mode_q == SFP_RX);
    end
  end

  a_cont_rx_pin: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    (cont_q && mode_q == SFP_RX) |=> SERIAL_DATA_PIN_OE &&
    (SERIAL_DATA_PIN_O == $past(DEMOD_BIT)))
    else $error("Data pin not driven in continuous receive.");

  // ----------------------------------------------------------------------
  // Configuration space and read word
  // ----------------------------------------------------------------------
  logic [7:0] cfg_mem [0:127];
  logic [7:0] status_byte;
  logic [7:0] mode_byte;
  logic [7:0] rd_mux;
  logic       has_data_q;
  logic       freeze;

  always_comb begin
    status_byte                  = 8'h00;
    status_byte[`SFP_ST_HAS_DATA] = has_data_q;
    status_byte[`SFP_ST_FULL]     = full;
    status_byte[`SFP_ST_OVERRUN]  = overrun_q;
    status_byte[`SFP_ST_SETTLED]  = settled_q;
  end

  always_comb begin
    mode_byte                     = 8'h00;
    mode_byte[2:0]                = mode_q;
    mode_byte[`SFP_MODE_CONT_BIT] = cont_q;
  end

  // The word for the next byte is taken before this byte's write lands.
  assign rd_mux = (addr_d == `SFP_FIFO_ADDR)   ? fifo_mem[rd_ptr_d] :
                  (addr_d == `SFP_MODE_ADDR)   ? mode_byte :
                  (addr_d == `SFP_STATUS_ADDR) ? status_byte :
                  cfg_mem[addr_d];

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 8'h00;
    end else if (byte_evt) begin
      rdata_q <= rd_mux;
    end
  end

  // Plain storage for every address without special meaning.
  always_ff @(posedge MCLK) begin
    if (cfg_wr && addr_q != `SFP_MODE_ADDR && addr_q != `SFP_STATUS_ADDR) begin
      cfg_mem[addr_q] <= evt_q.data;
    end
  end

  // During a buffer read frame the level indication holds until select rises.
  assign freeze = ~ss_s & frame_q & ~wnr_q & at_fifo;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      has_data_q <= 1'b0;
    end else if (!freeze) begin
      has_data_q <= ~empty;
    end
  end

  assign BUFFER_HAS_DATA = has_data_q;

  a_has_data: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    (!freeze && empty) ##1 (!freeze && empty) |-> !has_data_q)
    else $error("Has-data high with an empty buffer.");

endmodule : sfp_port

// file: logic/sfp_sync3.sv
// Three-stage synchroniser that accepts a change once stages agree.
`timescale 1ns/1ps

module sfp_sync3 #(
  parameter logic INIT = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);

  logic f1_q;
  logic f2_q;
  logic f3_q;

  // The first stage feeds only the second; the filter looks at two and three.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f1_q <= INIT;
      f2_q <= INIT;
      f3_q <= INIT;
      q    <= INIT;
    end else begin
      f1_q <= d;
      f2_q <= f1_q;
      f3_q <= f2_q;
      if (f2_q == f3_q) begin
        q <= f3_q;
      end
    end
  end

endmodule : sfp_sync3

// file: verification/sfp_host.sv
// Host model that masters the serial port with its clock idle low.
`timescale 1ns/1ps

module sfp_host (
  output logic      sck,
  output logic      ss_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sck  = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end

  // Select edges keep more than four system cycles between frames.
  task automatic sel(input logic on);
    #80 ss_n = !on;
    #80;
  endtask : sel

  // Data changes while the clock is low; the answer is taken at the rise.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #80 sck = 1'b1;
      rx[i] = miso;
      #80 sck = 1'b0;
    end
    mosi = ~tx[0]; // A released line must not keep the last bit.
  endtask : xfer

  // One frame: address byte, then data bytes, returning what came back.
  task automatic frame(input logic wnr, input logic [6:0] a,
                       input logic [7:0] d[$], output logic [7:0] q[$]);
    logic [7:0] r;
    q = {};
    sel(1'b1);
    xfer({wnr, a}, r);
    foreach (d[i]) begin
      xfer(d[i], r);
      q.push_back(r);
    end
    sel(1'b0);
  endtask : frame
endmodule : sfp_host

// file: verification/tb.sv
// Self-checking bench for the serial register and buffer port.
`timescale 1ns/1ps
`include "sfp_defs.svh"

module tb;
  typedef struct packed {
    logic [6:0] a;
    logic [7:0] d1;
    logic [7:0] d2;
  } sfp_row_t;

  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       demod = 1'b0;
  logic       pin_i = 1'b0;
  logic       sck, ss_n, mosi, miso, miso_oe, miso_w, mod_bit;
  logic       pin_o, pin_oe, has_data, ovr, settled;
  int         fails = 0;
  int         n_checks = 0;
  logic [7:0] q[$];
  logic [7:0] d[$];
  sfp_row_t   rows[3] = '{'{7'h05, 8'hA5, 8'h5A}, '{7'h7F, 8'h00, 8'hFF},
                          '{7'h10, 8'h81, 8'h7E}};
  // First byte sent by the packet shifter; its top bit marks the start.
  localparam logic [7:0] TX_PAT = 8'hB4;

  always #5 mclk = ~mclk;

  // A released data line shows the inverse, never a stale bit.
  assign miso_w = miso_oe ? miso : ~miso;

  sfp_port i_sfp_port (.MCLK(mclk), .RST_N(rst_n), .SCK(sck),
    .SLAVE_SELECT_N(ss_n), .MOSI(mosi), .MISO(miso), .MISO_OE(miso_oe),
    .DEMOD_BIT(demod), .MOD_TX_BIT(mod_bit), .SERIAL_DATA_PIN_I(pin_i),
    .SERIAL_DATA_PIN_O(pin_o), .SERIAL_DATA_PIN_OE(pin_oe),
    .BUFFER_HAS_DATA(has_data), .BUFFER_OVERRUN_FLAG(ovr),
    .MODE_SETTLED_FLAG(settled));

  sfp_host i_sfp_host (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso_w));

  // Compare one value and count it.
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Print the counts and the verdict, then end the run.
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // Let flags cross into the system clock domain before looking.
  task automatic settle;
    repeat (10) @(posedge mclk);
    #1;
  endtask : settle

  // Main sequence: reset, table of single accesses, then awkward cases.
  initial begin
    #15;
    check("oe_in_reset", {7'h00, miso_oe}, 8'h00);
    check("settled_rst", {7'h00, settled}, 8'h01);
    @(posedge mclk) #1 rst_n = 1'b1;
    settle();
    foreach (rows[i]) begin
      i_sfp_host.frame(1'b1, rows[i].a, {rows[i].d1}, q);
      i_sfp_host.frame(1'b1, rows[i].a, {rows[i].d2}, q);
      check("old_content", q[0], rows[i].d1);
      i_sfp_host.frame(1'b0, rows[i].a, {8'h00}, q);
      check("read_back", q[0], rows[i].d2);
    end
    $display("single accesses done");
    // Burst write and read back from the same start address.
    i_sfp_host.frame(1'b1, 7'h20, {8'h11, 8'h22, 8'h33}, q);
    i_sfp_host.frame(1'b0, 7'h20, {8'h00, 8'h00, 8'h00}, q);
    foreach (q[i]) check("burst", q[i], 8'h11 * (i + 1));
    check("oe_idle", {7'h00, miso_oe}, 8'h00);
    $display("burst done");
    // Buffer keeps its address and order across a frame.
    i_sfp_host.frame(1'b1, 7'h00, {8'hC3, 8'h3C, 8'h96}, q);
    settle();
    check("has_data", {7'h00, has_data}, 8'h01);
    i_sfp_host.frame(1'b0, 7'h00, {8'h00, 8'h00, 8'h00}, q);
    check("pop0", q[0], 8'hC3);
    check("pop1", q[1], 8'h3C);
    check("pop2", q[2], 8'h96);
    settle();
    check("empty", {7'h00, has_data}, 8'h00);
    $display("buffer order done");
    // Fill to exactly 66, then one more overruns; clearing flushes.
    d = {};
    for (int i = 0; i < 66; i++) d.push_back(i[7:0]);
    i_sfp_host.frame(1'b1, 7'h00, d, q);
    settle();
    check("no_ovr_66", {7'h00, ovr}, 8'h00);
    i_sfp_host.frame(1'b1, 7'h00, {8'hEE}, q);
    settle();
    check("ovr_67", {7'h00, ovr}, 8'h01);
    i_sfp_host.frame(1'b1, 7'h02, {8'h04}, q);
    settle();
    check("ovr_clr", {7'h00, ovr}, 8'h00);
    check("clr_flush", {7'h00, has_data}, 8'h00);
    $display("overrun done");
    // Entering receive flushes; continuous receive drives the data pin.
    i_sfp_host.frame(1'b1, 7'h00, {8'h77}, q);
    i_sfp_host.frame(1'b1, 7'h01, {8'h0C}, q);
    @(posedge mclk) #1 demod = 1'b1;
    settle();
    check("rx_flush", {7'h00, has_data}, 8'h00);
    check("pin_oe", {7'h00, pin_oe}, 8'h01);
    check("pin_hi", {7'h00, pin_o}, 8'h01);
    @(posedge mclk) #1 demod = 1'b0;
    settle();
    check("pin_lo", {7'h00, pin_o}, 8'h00);
    $display("continuous receive done");
    // Packet transmit: three bytes queued in standby, then the first is checked as sent MSB first.
    i_sfp_host.frame(1'b1, 7'h01, {8'h01}, q);
    i_sfp_host.frame(1'b1, 7'h00, {TX_PAT, 8'h5A, 8'h3C}, q);
    i_sfp_host.frame(1'b1, 7'h01, {8'h03}, q);
    repeat (3 * `SFP_BIT_CYCLES) begin
      @(posedge mclk);
      #1;
      if (mod_bit) break;
    end
    // Sample each bit half a bit time after its start.
    for (int b = 7; b >= 0; b--) begin
      repeat (`SFP_BIT_CYCLES / 2) @(posedge mclk);
      #1;
      check("tx_bit", {7'h00, mod_bit}, {7'h00, TX_PAT[b]});
      repeat (`SFP_BIT_CYCLES / 2) @(posedge mclk);
    end
    // Sleep while the second byte is on air: wait for settled, then look.
    i_sfp_host.frame(1'b1, 7'h01, {8'h00}, q);
    check("settled_lo", {7'h00, settled}, 8'h00);
    repeat (10 * `SFP_BIT_CYCLES) begin
      @(posedge mclk);
      #1;
      if (settled) break;
    end
    settle();
    check("settled_hi", {7'h00, settled}, 8'h01);
    check("tx_flush", {7'h00, has_data}, 8'h00);
    $display("packet transmit done");
    // Continuous transmit passes the data pin to the modulator.
    @(posedge mclk) #1 pin_i = 1'b1;
    i_sfp_host.frame(1'b1, 7'h01, {8'h0B}, q);
    settle();
    check("ctx_hi", {7'h00, mod_bit}, 8'h01);
    @(posedge mclk) #1 pin_i = 1'b0;
    settle();
    check("ctx_lo", {7'h00, mod_bit}, 8'h00);
    $display("continuous transmit done");
    // Packet receive: ones for about twelve bit times give one full byte.
    @(posedge mclk) #1 demod = 1'b1;
    i_sfp_host.frame(1'b1, 7'h01, {8'h04}, q);
    repeat (9 * `SFP_BIT_CYCLES) @(posedge mclk);
    #1;
    i_sfp_host.frame(1'b1, 7'h01, {8'h01}, q);
    settle();
    check("rx_has", {7'h00, has_data}, 8'h01);
    i_sfp_host.frame(1'b0, 7'h00, {8'h00}, q);
    check("rx_byte", q[0], 8'hFF);
    $display("packet receive done");
    stop_test();
  end

  // Watchdog sized at about two and a half times the expected run of about 195 us.
  initial begin
    #500000;
    fails++;
    $display("watchdog expired");
    stop_test();
  end
endmodule : tb
